//--- ipo_defs.vh
// register map, field positions and reset values of the bus pin override
`ifndef IPO_DEFS_VH
`define IPO_DEFS_VH

// register byte offsets (one aligned 32-bit word each)
`define IPO_OFS_CTRL      4'h0
`define IPO_OFS_LATCH     4'h4
`define IPO_OFS_DIR       4'h8
`define IPO_OFS_PINS      4'hc

// serial_bus_ctrl_reg fields
`define IPO_CTRL_EN_BIT   0
`define IPO_CTRL_PED_BIT  2
`define IPO_CTRL_PEC_BIT  3

// port latch / direction / pin level fields
`define IPO_DATA_BIT      0
`define IPO_CLK_BIT       1

// reset values
`define IPO_CTRL_RST      4'h0
`define IPO_LATCH_RST     2'h3
`define IPO_DIR_RST       2'h0

// bus answer latency in cycles of waitrequest high
`define IPO_WAIT_CYCLES   1

`endif

//--- ipo_sync3.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module ipo_sync3 #(
   parameter WIDTH = 2
) (
   input  wire             clk_i,
   input  wire             srst_i,
   input  wire [WIDTH-1:0] async_i,
   input  wire [WIDTH-1:0] rst_val_i,
   output wire [WIDTH-1:0] level_o
);
   `include "ipo_defs.vh"

   reg [WIDTH-1:0] s1_q;   // metastability catcher, read only by s2
   reg [WIDTH-1:0] s2_q;   // second stage
   reg [WIDTH-1:0] s3_q;   // third stage
   reg [WIDTH-1:0] lvl_q;  // filtered level

   ////////////////////////////////////////////////////////////////////
   // shift chain; a change counts once stages two and three agree
   always @(posedge clk_i) begin
      if (srst_i) begin
         // idle level of the pins, so no false edge follows reset
         s1_q  <= rst_val_i;
         s2_q  <= rst_val_i;
         s3_q  <= rst_val_i;
         lvl_q <= rst_val_i;
      end else begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // bitwise agreement keeps a single-cycle glitch out
         lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
      end
   end

   assign level_o = lvl_q;
endmodule

//--- ipo_pin_override.v
// two-wire bus pin function select with avalon-mm register access
//
// Behaviour
// - override acts only while interface enabled
// - enabled interface always sees both pin levels
// - data override bit 2, clock bit 3
// - data override: data pin becomes port output
// - clock override: clock pin becomes port output
// - overridden pin driven from latch bit 0/1
// - pin level register reads actual bus levels
`timescale 1ns/1ps

module ipo_pin_override (
   input  wire        clk_i,
   input  wire        srst_i,
   // avalon-mm slave
   input  wire [3:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   input  wire [3:0]  avs_byteenable_i,
   output wire [31:0] avs_readdata_o,
   output wire        avs_waitrequest_o,
   // serial bus interface core side
   input  wire        iface_data_out_i,
   input  wire        iface_clock_out_i,
   output wire        iface_data_in_o,
   output wire        iface_clock_in_o,
   output wire        serial_bus_iface_enable_o,
   // bus_data_pin, open drain in bus mode
   input  wire        bus_data_pin_i,
   output wire        bus_data_pin_o,
   output wire        bus_data_pin_oe_o,
   // bus_clock_pin, open drain in bus mode
   input  wire        bus_clock_pin_i,
   output wire        bus_clock_pin_o,
   output wire        bus_clock_pin_oe_o
);
   `include "ipo_defs.vh"

   ////////////////////////////////////////////////////////////////////
   // state
   reg  [3:0]  ctrl_q;      // serial_bus_ctrl_reg low nibble
   reg  [1:0]  latch_q;     // port_latch_bit1..0
   reg  [1:0]  dir_q;       // port direction, 1 = output
   reg         ack_q;       // high in the answer cycle
   reg  [31:0] rdata_q;     // read data, loaded in the wait cycle
   reg  [31:0] rdata_d;     // read mux
   reg         data_o_q;    // registered data pin level
   reg         data_oe_q;   // registered data pin enable
   reg         clock_o_q;   // registered clock pin level
   reg         clock_oe_q;  // registered clock pin enable
   reg         data_o_d;
   reg         data_oe_d;
   reg         clock_o_d;
   reg         clock_oe_d;

   wire [1:0]  pin_lvl;     // filtered pin levels {clock, data}
   wire        req;         // any bus request
   wire        wr_now;      // write takes effect this edge
   wire        iface_en;    // interface enable bit
   wire        data_ovr;    // data pin port override, active
   wire        clock_ovr;   // clock pin port override, active

   ////////////////////////////////////////////////////////////////////
   // pin input synchronisers; pins idle high like a pulled-up bus
   // a pin change reaches the core and the pin register four edges later
   // chain resets to the idle bus level, so the core sees no false edge
   ipo_sync3 #(
      .WIDTH     (2)
   ) u_pin_sync (
      .clk_i     (clk_i),
      .srst_i    (srst_i),
      .async_i   ({bus_clock_pin_i, bus_data_pin_i}),
      .rst_val_i (2'h3),
      .level_o   (pin_lvl)
   );

   // interface inputs stay connected whatever the mode
   assign iface_data_in_o  = pin_lvl[`IPO_DATA_BIT];
   assign iface_clock_in_o = pin_lvl[`IPO_CLK_BIT];

   ////////////////////////////////////////////////////////////////////
   // avalon-mm handshake: one wait cycle, then the answer
   // waitrequest is combinational so the first request cycle always waits;
   // the fixed single wait lets read data come straight from a register
   assign req               = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_q;
   assign wr_now            = avs_write_i & ack_q;
   assign avs_readdata_o    = rdata_q;

   // ack toggles so that every request sees exactly one wait cycle
   always @(posedge clk_i) begin
      if (srst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read mux; only address bits 3:2 are decoded, so unaligned offsets read their word
   always @* begin
      rdata_d = 32'h0000_0000;
      case (avs_address_i[3:2])
         2'h0: begin
            rdata_d[3:0] = ctrl_q;
         end
         2'h1: begin
            rdata_d[1:0] = latch_q;
         end
         2'h2: begin
            rdata_d[1:0] = dir_q;
         end
         2'h3: begin
            // actual bus levels, independent of override bits
            rdata_d[1:0] = pin_lvl;
         end
         default: begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   // read data captured in the wait cycle so it stands at the answer
   always @(posedge clk_i) begin
      if (srst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read_i & ~ack_q) begin
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register writes, lane 0 only; other lanes hold reserved bits
   // a write with lane 0 disabled changes nothing
   // the pin level offset has no storage behind it
   always @(posedge clk_i) begin
      if (srst_i) begin
         ctrl_q  <= `IPO_CTRL_RST;
         latch_q <= `IPO_LATCH_RST;
         dir_q   <= `IPO_DIR_RST;
      end else if (wr_now & avs_byteenable_i[0]) begin
         case (avs_address_i[3:2])
            2'h0: begin
               // bit 1 reserved, kept zero
               ctrl_q <= avs_writedata_i[3:0] & 4'hd;
            end
            2'h1: begin
               latch_q <= avs_writedata_i[1:0];
            end
            2'h2: begin
               dir_q <= avs_writedata_i[1:0];
            end
            default: begin
               // pin level register is read only
               ctrl_q <= ctrl_q;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // function select
   // enable bit also goes out to the core as its on/off control
   assign iface_en  = ctrl_q[`IPO_CTRL_EN_BIT];
   assign serial_bus_iface_enable_o = iface_en;
   // selects mean nothing while the interface is off
   assign data_ovr  = iface_en & ctrl_q[`IPO_CTRL_PED_BIT];
   assign clock_ovr = iface_en & ctrl_q[`IPO_CTRL_PEC_BIT];

   // pin drive per mode
   // three cases per pin:
   //   interface off      : direction and latch, plain port
   //   on, select clear   : open drain from the core output
   //   on, select set     : push-pull from the latch, core ignored
   // override forces drive whatever the direction bit says
   always @* begin
      data_o_d   = latch_q[`IPO_DATA_BIT];
      data_oe_d  = dir_q[`IPO_DATA_BIT];
      clock_o_d  = latch_q[`IPO_CLK_BIT];
      clock_oe_d = dir_q[`IPO_CLK_BIT];
      if (!iface_en) begin
         // plain port i/o under the direction register
         data_o_d   = latch_q[`IPO_DATA_BIT];
         data_oe_d  = dir_q[`IPO_DATA_BIT];
         clock_o_d  = latch_q[`IPO_CLK_BIT];
         clock_oe_d = dir_q[`IPO_CLK_BIT];
      end else begin
         if (data_ovr) begin
            // port output, interface data output ignored
            data_o_d  = latch_q[`IPO_DATA_BIT];
            data_oe_d = 1'b1;
         end else begin
            // open drain: only pull low, release for high
            data_o_d  = 1'b0;
            data_oe_d = ~iface_data_out_i;
         end
         if (clock_ovr) begin
            // port output, interface clock output ignored
            clock_o_d  = latch_q[`IPO_CLK_BIT];
            clock_oe_d = 1'b1;
         end else begin
            clock_o_d  = 1'b0;
            clock_oe_d = ~iface_clock_out_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin outputs from flops; costs one cycle, avoids mux glitches
   always @(posedge clk_i) begin
      if (srst_i) begin
         data_o_q   <= 1'b0;
         data_oe_q  <= 1'b0;
         clock_o_q  <= 1'b0;
         clock_oe_q <= 1'b0;
      end else begin
         data_o_q   <= data_o_d;
         data_oe_q  <= data_oe_d;
         clock_o_q  <= clock_o_d;
         clock_oe_q <= clock_oe_d;
      end
   end

   assign bus_data_pin_o     = data_o_q;
   assign bus_data_pin_oe_o  = data_oe_q;
   assign bus_clock_pin_o    = clock_o_q;
   assign bus_clock_pin_oe_o = clock_oe_q;
endmodule

//--- ipo_bus_agent.sv
// other stations on the two-wire bus: pull-up and wired-and pull-down
`timescale 1ns/1ps
module ipo_bus_agent (
   input  wire [1:0] oe_i,
   input  wire [1:0] o_i,
   input  wire [1:0] pull_low_i,
   output wire [1:0] level_o
);
   // a released line floats to the pull-up level, any station can pull low
   assign level_o = ~pull_low_i & (~oe_i | o_i);
endmodule

//--- ipo_pin_override_asserts.sv
// concurrent checks on the pin override ports
`timescale 1ns/1ps
module ipo_pin_override_asserts (
   input wire        clk_i,
   input wire        srst_i,
   input wire [3:0]  avs_address_i,
   input wire        avs_read_i,
   input wire        avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0]  avs_byteenable_i,
   input wire        avs_waitrequest_o,
   input wire        iface_data_out_i,
   input wire        iface_clock_out_i,
   input wire        iface_data_in_o,
   input wire        iface_clock_in_o,
   input wire        serial_bus_iface_enable_o,
   input wire        bus_data_pin_i,
   input wire        bus_data_pin_o,
   input wire        bus_data_pin_oe_o,
   input wire        bus_clock_pin_i,
   input wire        bus_clock_pin_o,
   input wire        bus_clock_pin_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   wire req = avs_read_i | avs_write_i;
   wire wr  = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
   logic [3:0] ctrl_q;   // shadow of control word
   logic [1:0] lat_q;    // shadow of port latch
   logic [1:0] dir_q;    // shadow of direction
   //////////////////////////////////////////////////////////////////////
   // shadow registers, updated at the write answer edge only
   always @(posedge clk_i) begin
      if (srst_i) begin
         ctrl_q <= 4'h0;
         lat_q  <= 2'h3;
         dir_q  <= 2'h0;
      end else if (wr && avs_address_i[3:2] == 2'h0) begin
         ctrl_q <= avs_writedata_i[3:0] & 4'hd;
      end else if (wr && avs_address_i[3:2] == 2'h1) begin
         lat_q <= avs_writedata_i[1:0];
      end else if (wr && avs_address_i[3:2] == 2'h2) begin
         dir_q <= avs_writedata_i[1:0];
      end
   end
   //////////////////////////////////////////////////////////////////////
   sequence s_req_wait;
      req && avs_waitrequest_o;
   endsequence
   a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest_o)
      else $error("first request cycle without wait");
   a_wait_one: assert property (s_req_wait ##1 req |-> !avs_waitrequest_o)
      else $error("answer later than one wait cycle");
   a_en_follow: assert property (
      serial_bus_iface_enable_o == ctrl_q[0])
      else $error("enable output differs from control bit");
   a_data_ovr: assert property (ctrl_q[0] && ctrl_q[2] |=>
      bus_data_pin_oe_o && bus_data_pin_o == $past(lat_q[0]))
      else $error("data pin not driven from latch");
   a_clk_ovr: assert property (ctrl_q[0] && ctrl_q[3] |=>
      bus_clock_pin_oe_o && bus_clock_pin_o == $past(lat_q[1]))
      else $error("clock pin not driven from latch");
   a_bus_mode: assert property (ctrl_q[0] && !ctrl_q[2] |=>
      bus_data_pin_oe_o == !$past(iface_data_out_i) && !bus_data_pin_o)
      else $error("data pin not open drain from core");
   a_clk_bus: assert property (ctrl_q[0] && !ctrl_q[3] |=>
      bus_clock_pin_oe_o == !$past(iface_clock_out_i) && !bus_clock_pin_o)
      else $error("clock pin not open drain from core");
   a_port_mode: assert property (!ctrl_q[0] |=>
      {bus_data_pin_oe_o, bus_data_pin_o, bus_clock_pin_oe_o, bus_clock_pin_o}
      == $past({dir_q[0], lat_q[0], dir_q[1], lat_q[1]}))
      else $error("disabled pins not under port control");
   a_iface_sees: assert property (
      $stable({bus_data_pin_i, bus_clock_pin_i})[*6]
      |-> {iface_data_in_o, iface_clock_in_o}
      == {bus_data_pin_i, bus_clock_pin_i})
      else $error("core does not see pin levels");
endmodule
bind ipo_pin_override ipo_pin_override_asserts u_ipo_pin_override_asserts (.*);

//--- testbench.sv
// self-checking bench for the bus pin override
`timescale 1ns/1ps
module testbench;
   logic clk_i = 0, srst_i = 1, avs_read_i = 0, avs_write_i = 0;
   logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'h0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic iface_data_out_i = 0, iface_clock_out_i = 1;
   logic [1:0] pull_low = 2'h0, lvl;
   wire [31:0] avs_readdata_o;
   wire avs_waitrequest_o, iface_data_in_o, iface_clock_in_o;
   wire serial_bus_iface_enable_o, bus_data_pin_o, bus_data_pin_oe_o;
   wire bus_clock_pin_o, bus_clock_pin_oe_o;
   wire bus_data_pin_i = lvl[0];
   wire bus_clock_pin_i = lvl[1];
   wire [1:0] dpin = {bus_data_pin_oe_o, bus_data_pin_o};
   wire [1:0] cpin = {bus_clock_pin_oe_o, bus_clock_pin_o};
   int fails = 0, samples_checked = 0;
   logic [31:0] dummy_q;
   logic [3:0] cv [5] = '{4'h0, 4'h1, 4'h5, 4'h9, 4'hd};
   ipo_pin_override u_ipo_pin_override (
      .clk_i                     (clk_i),
      .srst_i                    (srst_i),
      .avs_address_i             (avs_address_i),
      .avs_read_i                (avs_read_i),
      .avs_write_i               (avs_write_i),
      .avs_writedata_i           (avs_writedata_i),
      .avs_byteenable_i          (avs_byteenable_i),
      .avs_readdata_o            (avs_readdata_o),
      .avs_waitrequest_o         (avs_waitrequest_o),
      .iface_data_out_i          (iface_data_out_i),
      .iface_clock_out_i         (iface_clock_out_i),
      .iface_data_in_o           (iface_data_in_o),
      .iface_clock_in_o          (iface_clock_in_o),
      .serial_bus_iface_enable_o (serial_bus_iface_enable_o),
      .bus_data_pin_i            (bus_data_pin_i),
      .bus_data_pin_o            (bus_data_pin_o),
      .bus_data_pin_oe_o         (bus_data_pin_oe_o),
      .bus_clock_pin_i           (bus_clock_pin_i),
      .bus_clock_pin_o           (bus_clock_pin_o),
      .bus_clock_pin_oe_o        (bus_clock_pin_oe_o)
   );
   ipo_bus_agent u_ipo_bus_agent (
      .oe_i       ({bus_clock_pin_oe_o, bus_data_pin_oe_o}),
      .o_i        ({bus_clock_pin_o, bus_data_pin_o}),
      .pull_low_i (pull_low),
      .level_o    (lvl)
   );
   always #2 clk_i = ~clk_i;
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one bus cycle, held until waitrequest is sampled low
   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      avs_write_i <= w;
      avs_read_i <= !w;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(1'b1, a, d, 4'h1, q);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      acc(1'b0, a, 32'h0, 4'hf, q);
      chk(q, e);
   endtask
   // expected {oe, o} of pin k for control c, latch 01, direction 10
   function automatic logic [1:0] pin_exp(input logic [3:0] c,
                                          input logic core, input int k);
      if (!c[0]) return {k == 1, k == 0};
      if (c[2+k]) return {1'b1, k == 0};
      return {!core, 1'b0};
   endfunction
   task final_report;
      if (fails == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   initial begin
      #20000;
      fails++;
      final_report;
   end
   initial begin
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h3);
      rd(4'h8, 32'h0);
      wr(4'h0, 32'hff);
      rd(4'h0, 32'hd);
      acc(1'b1, 4'h0, 32'h0, 4'h0, dummy_q);
      rd(4'h0, 32'hd);
      wr(4'h4, 32'h1);
      wr(4'h8, 32'h2);
      foreach (cv[i]) begin
         wr(4'h0, {28'h0, cv[i]});
         repeat (2) @(posedge clk_i);
         chk(dpin, pin_exp(cv[i], 1'b0, 0));
         chk(cpin, pin_exp(cv[i], 1'b1, 1));
         // swap the core outputs; overridden pins must ignore them
         iface_data_out_i  <= 1'b1;
         iface_clock_out_i <= 1'b0;
         repeat (2) @(posedge clk_i);
         chk(dpin, pin_exp(cv[i], 1'b1, 0));
         chk(cpin, pin_exp(cv[i], 1'b0, 1));
         iface_data_out_i  <= 1'b0;
         iface_clock_out_i <= 1'b1;
      end
      // both overridden: new latch value must reach the pins
      wr(4'h4, 32'h2);
      repeat (8) @(posedge clk_i);
      chk(dpin, 2'h2);
      chk(cpin, 2'h3);
      rd(4'hc, 32'h2);
      wr(4'h4, 32'h1);
      pull_low <= 2'h1;
      repeat (8) @(posedge clk_i);
      rd(4'hc, 32'h0);
      chk(iface_data_in_o, 1'b0);
      chk(iface_clock_in_o, 1'b0);
      pull_low <= 2'h0;
      repeat (8) @(posedge clk_i);
      rd(4'hc, 32'h1);
      // pin level word is read only
      wr(4'hc, 32'h3);
      rd(4'hc, 32'h1);
      wr(4'h0, 32'h0);
      repeat (8) @(posedge clk_i);
      rd(4'hc, 32'h1);
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      rd(4'h4, 32'h3);
      rd(4'h0, 32'h0);
      rd(4'h8, 32'h0);
      final_report;
   end
endmodule
